/* File: pfs_defs.svh */
// Register offsets, field positions, reset values and timing counts of the supervisor
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
// ==========================================
// Serial bus
`define PFS_I2C_ADDR 7'h48
// ==========================================
// Register offsets
`define PFS_OFS_CH_EN_CMD 8'h00
`define PFS_OFS_EN_CONFIG 8'h01
`define PFS_OFS_UV_WARN_PRI 8'h02
`define PFS_OFS_UV_WARN_SEC 8'h03
`define PFS_OFS_UV_FAULT_PRI 8'h04
`define PFS_OFS_UV_FAULT_SEC 8'h05
`define PFS_OFS_THERM_SHDN 8'h06
`define PFS_OFS_THERM_RESTART 8'h07
`define PFS_OFS_FAULT_CFG 8'h08
`define PFS_OFS_PRI_READBACK 8'h09
`define PFS_OFS_SEC_READBACK 8'h0a
`define PFS_OFS_TEMP_READBACK 8'h0b
`define PFS_OFS_PROT_FLAGS 8'h0c
`define PFS_OFS_CHAN_FLAGS 8'h0d
`define PFS_OFS_CHIP_RESTART 8'h18
`define PFS_OFS_VOUT_TARGET 6'h04
`define PFS_OFS_VOUT_READBACK 6'h05
// ==========================================
// Fault configuration fields
`define PFS_CFG_UV_AUTO 0
`define PFS_CFG_OT_AUTO 1
`define PFS_CFG_OT_WARN10 2
`define PFS_CFG_UV_GPIO 3
// ==========================================
// Reset values
`define PFS_RST_UV_WARN 8'h46
`define PFS_RST_UV_FAULT 8'h41
`define PFS_RST_THERM_SHDN 7'h2c
`define PFS_RST_THERM_RESTART 7'h26
`define PFS_RST_FAULT_CFG 8'h03
`define PFS_RST_VOUT_TARGET 8'h14
// ==========================================
// Temperature warning offsets in 5 K steps
`define PFS_OT_OFS_5 7'h01
`define PFS_OT_OFS_10 7'h02
// ==========================================
// Timing
`define PFS_CLK_HZ 50000000
`define PFS_OCP_RESTART_MS 200
`endif

/* File: pfs_pkg.sv */
// Types shared by the power rail fault supervisor
package pfs_pkg;
  // ==========================================
  // Serial slave states
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_BYTE, I2C_RBYTE, I2C_RACK
  } pfs_i2c_e;
  // ==========================================
  // Input and thermal protection flags
  typedef struct packed {
    logic otFault;
    logic otWarn;
    logic uvFaultSec;
    logic uvFaultPri;
    logic uvWarnSec;
    logic uvWarnPri;
  } pfs_prot_s;
  typedef logic [3:0] pfs_chan_t;
  typedef logic [7:0] pfs_byte_t;
endpackage : pfs_pkg

/* File: pfs_top.sv */
// Power rail fault supervisor: enable, sequencing, protection and serial registers
// Function
// [RULE_01] System holds chip enable low until the digital supply regulates.
// [RULE_02] Chip enable raises a ready flag; only then does the serial slave acknowledge.
// [RULE_03] Always-on channels enable automatically when chip enable rises.
// [RULE_04] GPIO-controlled channels enable when their GPIO input is asserted.
// [RULE_05] Chip enable high enables the device; low disables it entirely.
// [RULE_06] A serial restart command resets the chip.
// [RULE_07] Channels enable from start-up defaults, GPIO pins or serial command.
// [RULE_08] High-side and low-side gate drives are never active together.
// [RULE_09] Over-current shuts the channel down and restarts it after 200 ms.
// [RULE_10] Over-voltage on a channel shuts that channel down.
// [RULE_11] Per-input undervoltage warning level, 100 mV steps, sets flag, optional GPIO.
// [RULE_12] Per-input undervoltage fault level, 100 mV steps, reported in flags.
// [RULE_13] Undervoltage fault on either input sets fault and shuts all channels.
// [RULE_14] Both input voltages read back at 100 mV per LSB.
// [RULE_15] Optional auto-restart once input rises above the warning level.
// [RULE_16] Junction temperature reads back in kelvin, 5 K LSB, 200 K to 520 K.
// [RULE_17] Over-temperature warning sets 5 or 10 degrees below fault threshold.
// [RULE_18] Over-temperature fault sets fault and warning, shuts channels, bus stays alive.
// [RULE_19] Over-temperature threshold is a 7-bit setting with 5 K LSB.
// [RULE_20] Optional automatic restart below a separate restart temperature.
// [RULE_21] Output target is code times 50 mV; measured output readable per channel.
// [RULE_22] Host should program only even target codes above 2.5 V.
`timescale 1ns/1ns
`include "pfs_defs.svh"
module pfs_top
  import pfs_pkg::*;
#(
  parameter int OCP_RESTART_CYCLES = `PFS_OCP_RESTART_MS * (`PFS_CLK_HZ / 1000)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chipEnable,
  input wire pfs_chan_t nvmAlwaysOn,
  input wire pfs_chan_t nvmGpioCtl,
  input wire pfs_chan_t gpioIn,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire pfs_byte_t primaryInputAdc,
  input wire pfs_byte_t secondaryInputAdc,
  input wire logic [6:0] junctionTempAdc,
  input wire pfs_byte_t [3:0] outputVoltageAdc,
  input wire pfs_chan_t ovpTrip,
  input wire pfs_chan_t ocpTrip,
  input wire pfs_chan_t pwmDrive,
  output logic chipReady,
  output pfs_chan_t chanEnable,
  output pfs_chan_t gateHigh,
  output pfs_chan_t gateLow,
  output pfs_byte_t [3:0] outputVoltageTarget,
  output logic uvWarnGpio
);
  // ==========================================
  // Register state
  pfs_chan_t serialEn_reg, alwaysOn_reg, gpioCtl_reg;
  pfs_byte_t uvWarnPri_reg, uvWarnSec_reg, uvFaultPri_reg, uvFaultSec_reg, faultCfg_reg;
  logic [6:0] thermShdn_reg, thermRestart_reg, tempRb_reg;
  pfs_byte_t [3:0] voutTarget_reg, voutRb_reg;
  pfs_prot_s prot_reg, protNext;
  pfs_chan_t ovpFault_reg, ocpFault_reg, chanEn_reg, gh_reg, gl_reg;
  // ==========================================
  // Serial slave state
  pfs_i2c_e st_reg;
  logic [3:0] bitCnt_reg;
  pfs_byte_t shift_reg, ptr_reg, rdData, wrAddr_reg, wrData_reg, priRb_reg, secRb_reg;
  logic rw_reg, firstByte_reg, oe_reg, sclPrev_reg, sdaPrev_reg, wrStb_reg, chipReady_reg;
  // ==========================================
  // Chip clear: enable pin low or serial restart
  wire restartCmd = wrStb_reg && wrAddr_reg == `PFS_OFS_CHIP_RESTART; // RULE_06
  wire chipClear = !chipEnable || restartCmd; // RULE_05
  wire pfs_chan_t reEn = (wrStb_reg && wrAddr_reg == `PFS_OFS_CH_EN_CMD) ? wrData_reg[3:0] : 4'h0;
  wire wrFlags = wrStb_reg && wrAddr_reg == `PFS_OFS_PROT_FLAGS;
  wire sclRise = scl && !sclPrev_reg;
  wire sclFall = !scl && sclPrev_reg;
  wire startCond = scl && sclPrev_reg && sdaPrev_reg && !sdaIn;
  wire stopCond = scl && sclPrev_reg && !sdaPrev_reg && sdaIn;
  // ==========================================
  // Protection decode
  wire [6:0] otOfs = faultCfg_reg[`PFS_CFG_OT_WARN10] ? `PFS_OT_OFS_10 : `PFS_OT_OFS_5;
  wire otTrip = tempRb_reg >= thermShdn_reg; // RULE_19
  wire otNear = {1'b0, tempRb_reg} + {1'b0, otOfs} >= {1'b0, thermShdn_reg}; // RULE_17
  wire otClear = tempRb_reg < thermRestart_reg; // RULE_20
  wire uvPriTrip = priRb_reg <= uvFaultPri_reg; // RULE_12
  wire uvSecTrip = secRb_reg <= uvFaultSec_reg; // RULE_12
  wire globalOff = prot_reg.uvFaultPri || prot_reg.uvFaultSec || prot_reg.otFault; // RULE_13
  wire pfs_chan_t enRequest = alwaysOn_reg | (gpioCtl_reg & gpioIn) | serialEn_reg; // RULE_07
  wire pfs_chan_t enNext = chipReady_reg && !globalOff ?
    enRequest & ~ovpFault_reg & ~ocpFault_reg : 4'h0;
  // Both gates take a dead cycle on every transition
  wire pfs_chan_t ghNext = pwmDrive & chanEn_reg & ~gl_reg; // RULE_08
  wire pfs_chan_t glNext = ~pwmDrive & chanEn_reg & ~gh_reg; // RULE_08
  always_comb begin
    protNext.uvWarnPri = priRb_reg <= uvWarnPri_reg; // RULE_11
    protNext.uvWarnSec = secRb_reg <= uvWarnSec_reg; // RULE_11
    protNext.uvFaultPri = uvPriTrip || (prot_reg.uvFaultPri && !(wrFlags && wrData_reg[2]) &&
      !(faultCfg_reg[`PFS_CFG_UV_AUTO] && !protNext.uvWarnPri)); // RULE_15
    protNext.uvFaultSec = uvSecTrip || (prot_reg.uvFaultSec && !(wrFlags && wrData_reg[3]) &&
      !(faultCfg_reg[`PFS_CFG_UV_AUTO] && !protNext.uvWarnSec)); // RULE_15
    protNext.otFault = otTrip || (prot_reg.otFault && !(wrFlags && wrData_reg[5]) &&
      !(faultCfg_reg[`PFS_CFG_OT_AUTO] && otClear)); // RULE_20
    protNext.otWarn = otNear || protNext.otFault; // RULE_18
  end
  // ==========================================
  // Read mux
  always_comb begin
    rdData = 8'h00;
    unique case (ptr_reg)
      `PFS_OFS_CH_EN_CMD: rdData = {4'h0, serialEn_reg};
      `PFS_OFS_EN_CONFIG: rdData = {gpioCtl_reg, alwaysOn_reg};
      `PFS_OFS_UV_WARN_PRI: rdData = uvWarnPri_reg;
      `PFS_OFS_UV_WARN_SEC: rdData = uvWarnSec_reg;
      `PFS_OFS_UV_FAULT_PRI: rdData = uvFaultPri_reg;
      `PFS_OFS_UV_FAULT_SEC: rdData = uvFaultSec_reg;
      `PFS_OFS_THERM_SHDN: rdData = {1'b0, thermShdn_reg};
      `PFS_OFS_THERM_RESTART: rdData = {1'b0, thermRestart_reg};
      `PFS_OFS_FAULT_CFG: rdData = faultCfg_reg;
      `PFS_OFS_PRI_READBACK: rdData = priRb_reg; // RULE_14
      `PFS_OFS_SEC_READBACK: rdData = secRb_reg; // RULE_14
      `PFS_OFS_TEMP_READBACK: rdData = {1'b0, tempRb_reg}; // RULE_16
      `PFS_OFS_PROT_FLAGS: rdData = {2'b00, prot_reg};
      `PFS_OFS_CHAN_FLAGS: rdData = {ocpFault_reg, ovpFault_reg};
      default: begin
        if (ptr_reg[7:2] == `PFS_OFS_VOUT_TARGET) rdData = voutTarget_reg[ptr_reg[1:0]];
        if (ptr_reg[7:2] == `PFS_OFS_VOUT_READBACK) rdData = voutRb_reg[ptr_reg[1:0]]; // RULE_21
      end
    endcase
  end
  // ==========================================
  // Measurement capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      priRb_reg <= 8'h00;
      secRb_reg <= 8'h00;
      tempRb_reg <= 7'h00;
      voutRb_reg <= '0;
    end else begin
      priRb_reg <= primaryInputAdc; // RULE_14
      secRb_reg <= secondaryInputAdc;
      tempRb_reg <= junctionTempAdc; // RULE_16
      voutRb_reg <= outputVoltageAdc; // RULE_21
    end
  end
  // ==========================================
  // Configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chipReady_reg <= 1'b0;
      serialEn_reg <= 4'h0;
      alwaysOn_reg <= 4'h0;
      gpioCtl_reg <= 4'h0;
      uvWarnPri_reg <= `PFS_RST_UV_WARN;
      uvWarnSec_reg <= `PFS_RST_UV_WARN;
      uvFaultPri_reg <= `PFS_RST_UV_FAULT;
      uvFaultSec_reg <= `PFS_RST_UV_FAULT;
      thermShdn_reg <= `PFS_RST_THERM_SHDN;
      thermRestart_reg <= `PFS_RST_THERM_RESTART;
      faultCfg_reg <= `PFS_RST_FAULT_CFG;
      voutTarget_reg <= {4{`PFS_RST_VOUT_TARGET}};
    end else if (chipClear) begin
      chipReady_reg <= 1'b0; // RULE_05
      serialEn_reg <= 4'h0;
      alwaysOn_reg <= nvmAlwaysOn; // RULE_01
      gpioCtl_reg <= nvmGpioCtl; // RULE_01
      uvWarnPri_reg <= `PFS_RST_UV_WARN;
      uvWarnSec_reg <= `PFS_RST_UV_WARN;
      uvFaultPri_reg <= `PFS_RST_UV_FAULT;
      uvFaultSec_reg <= `PFS_RST_UV_FAULT;
      thermShdn_reg <= `PFS_RST_THERM_SHDN;
      thermRestart_reg <= `PFS_RST_THERM_RESTART;
      faultCfg_reg <= `PFS_RST_FAULT_CFG;
      voutTarget_reg <= {4{`PFS_RST_VOUT_TARGET}};
    end else begin
      chipReady_reg <= 1'b1; // RULE_02
      if (wrStb_reg) begin
        unique case (wrAddr_reg)
          `PFS_OFS_CH_EN_CMD: serialEn_reg <= wrData_reg[3:0]; // RULE_07
          `PFS_OFS_EN_CONFIG: {gpioCtl_reg, alwaysOn_reg} <= wrData_reg;
          `PFS_OFS_UV_WARN_PRI: uvWarnPri_reg <= wrData_reg;
          `PFS_OFS_UV_WARN_SEC: uvWarnSec_reg <= wrData_reg;
          `PFS_OFS_UV_FAULT_PRI: uvFaultPri_reg <= wrData_reg;
          `PFS_OFS_UV_FAULT_SEC: uvFaultSec_reg <= wrData_reg;
          `PFS_OFS_THERM_SHDN: thermShdn_reg <= wrData_reg[6:0]; // RULE_19
          `PFS_OFS_THERM_RESTART: thermRestart_reg <= wrData_reg[6:0];
          `PFS_OFS_FAULT_CFG: faultCfg_reg <= wrData_reg;
          default: begin
            if (wrAddr_reg[7:2] == `PFS_OFS_VOUT_TARGET) begin
              voutTarget_reg[wrAddr_reg[1:0]] <= wrData_reg; // RULE_21
            end
          end
        endcase
      end
    end
  end
  // ==========================================
  // Protection flags and channel control
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prot_reg <= '0;
      ovpFault_reg <= 4'h0;
      chanEn_reg <= 4'h0;
      gh_reg <= 4'h0;
      gl_reg <= 4'h0;
    end else if (chipClear) begin
      prot_reg <= '0;
      ovpFault_reg <= 4'h0;
      chanEn_reg <= 4'h0;
      gh_reg <= 4'h0;
      gl_reg <= 4'h0;
    end else begin
      prot_reg <= protNext; // RULE_13
      // Trip wins over a same-cycle host re-enable only while chanEn_reg is still set; once the channel is off, re-enable clears
      ovpFault_reg <= (ovpTrip & chanEn_reg) | (ovpFault_reg & ~reEn); // RULE_10
      chanEn_reg <= enNext; // RULE_03 RULE_04
      gh_reg <= ghNext;
      gl_reg <= glNext;
    end
  end
  // ==========================================
  // Over-current hold-off, one timer per channel
  for (genvar i = 0; i < 4; i++) begin : g_ocp
    logic [23:0] ocpCnt_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ocpFault_reg[i] <= 1'b0;
        ocpCnt_reg <= 24'h000000;
      end else if (chipClear) begin
        ocpFault_reg[i] <= 1'b0;
        ocpCnt_reg <= 24'h000000;
      end else if (ocpTrip[i] && chanEn_reg[i]) begin
        ocpFault_reg[i] <= 1'b1; // RULE_09
        ocpCnt_reg <= 24'h000000;
      end else if (ocpFault_reg[i]) begin
        ocpCnt_reg <= ocpCnt_reg + 24'h000001;
        if (ocpCnt_reg == 24'(OCP_RESTART_CYCLES - 1)) ocpFault_reg[i] <= 1'b0; // RULE_09
      end
    end
  end
  // ==========================================
  // Serial slave; keeps running through thermal faults
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= I2C_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      firstByte_reg <= 1'b0;
      oe_reg <= 1'b0;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      wrStb_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      wrData_reg <= 8'h00;
    end else begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sdaIn;
      wrStb_reg <= 1'b0;
      if (startCond) begin
        st_reg <= I2C_ADDR;
        bitCnt_reg <= 4'h0;
        oe_reg <= 1'b0;
      end else if (stopCond) begin
        st_reg <= I2C_IDLE;
        oe_reg <= 1'b0;
      end else begin
        unique case (st_reg)
          I2C_IDLE: ;
          I2C_ADDR, I2C_BYTE: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sdaIn};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              bitCnt_reg <= 4'h0;
              oe_reg <= 1'b1;
              st_reg <= I2C_ACK;
              if (st_reg == I2C_ADDR) begin
                rw_reg <= shift_reg[0];
                firstByte_reg <= 1'b1;
                // No acknowledge until the chip is ready
                if (shift_reg[7:1] != `PFS_I2C_ADDR || !chipReady_reg) begin // RULE_02
                  oe_reg <= 1'b0;
                  st_reg <= I2C_IDLE;
                end
              end else if (firstByte_reg) begin
                ptr_reg <= shift_reg;
                firstByte_reg <= 1'b0;
              end else begin
                wrStb_reg <= 1'b1;
                wrAddr_reg <= ptr_reg;
                wrData_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          I2C_ACK, I2C_RACK: begin
            if (sclRise && st_reg == I2C_RACK && sdaIn) begin
              st_reg <= I2C_IDLE;
            end else if (sclRise && st_reg == I2C_RACK) begin
              ptr_reg <= ptr_reg + 8'h01;
            end else if (sclFall) begin
              if (rw_reg) begin
                shift_reg <= rdData;
                oe_reg <= !rdData[7];
                bitCnt_reg <= 4'h1;
                st_reg <= I2C_RBYTE;
              end else begin
                oe_reg <= 1'b0;
                st_reg <= I2C_BYTE;
              end
            end
          end
          I2C_RBYTE: begin
            if (sclFall && bitCnt_reg == 4'h8) begin
              oe_reg <= 1'b0;
              st_reg <= I2C_RACK;
            end else if (sclFall) begin
              oe_reg <= !shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end
  // ==========================================
  // Outputs
  assign sdaOut = 1'b0;
  assign sdaOe = oe_reg;
  assign chipReady = chipReady_reg;
  assign chanEnable = chanEn_reg;
  assign gateHigh = gh_reg;
  assign gateLow = gl_reg;
  assign outputVoltageTarget = voutTarget_reg; // RULE_21
  assign uvWarnGpio = faultCfg_reg[`PFS_CFG_UV_GPIO] &&
    (prot_reg.uvWarnPri || prot_reg.uvWarnSec); // RULE_11
endmodule : pfs_top

/* File: pfs_host_model.sv */
// Serial host model driving the supervisor's open-drain two-wire bus
`timescale 1ns/1ns
`include "pfs_defs.svh"
module pfs_host_model
  import pfs_pkg::*;
(
  input wire logic mclk,
  input wire logic sdaOe,
  output logic scl,
  output wire logic sdaWire
);
  // ==========================================
  // Pulled-up wire, low while either side pulls
  logic sdaRel = 1'b1;
  assign sdaWire = sdaRel & ~sdaOe;
  initial scl = 1'b1;
  // ==========================================
  // Bus phases, three clocks each to stay above the two-clock minimum
  task automatic drive(input logic c, input logic d);
    scl = c;
    sdaRel = d;
    repeat (3) @(posedge mclk);
    #2;
  endtask : drive
  task automatic bit_io(input logic b, output logic r);
    drive(1'b0, b);
    drive(1'b1, b);
    r = sdaWire;
  endtask : bit_io
  // Start when s is 0, stop when s is 1; SCL is dropped first so no false condition
  task automatic cond(input logic s);
    drive(1'b0, ~s);
    drive(1'b1, ~s);
    drive(1'b1, s);
  endtask : cond
  task automatic xfer(input pfs_byte_t d, input logic mAck, output pfs_byte_t q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(mAck, r);
    ack = ~r;
  endtask : xfer
  // ==========================================
  // Register access: pointer write, then data or a repeated start and one read
  task automatic access(input logic rd, input logic [6:0] dev, input pfs_byte_t a,
    input pfs_byte_t d, output pfs_byte_t q, output logic ok);
    logic k0, k1, k2, k3;
    cond(1'b0);
    xfer({dev, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    if (rd) begin
      cond(1'b0);
      xfer({dev, 1'b1}, 1'b1, q, k2);
      xfer(8'hff, 1'b1, q, k3);
    end else begin
      xfer(d, 1'b1, q, k2);
    end
    cond(1'b1);
    ok = k0 & k1 & k2;
  endtask : access
endmodule : pfs_host_model

/* File: pfs_top_sva.sv */
// Port-level assertions for the power rail fault supervisor
`timescale 1ns/1ns
module pfs_top_sva
  import pfs_pkg::*;
#(
  parameter int OCP_RESTART_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chipEnable,
  input wire pfs_chan_t nvmAlwaysOn,
  input wire pfs_chan_t nvmGpioCtl,
  input wire pfs_chan_t gpioIn,
  input wire pfs_chan_t ovpTrip,
  input wire pfs_chan_t ocpTrip,
  input wire logic chipReady,
  input wire pfs_chan_t chanEnable,
  input wire pfs_chan_t gateHigh,
  input wire pfs_chan_t gateLow
);
  // Restart window; short simulation counts only, at least 7
  localparam int RS_LO = OCP_RESTART_CYCLES - 7;
  localparam int RS_HI = OCP_RESTART_CYCLES - 5;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Gate drive
  property p_gateExclusive;
    (gateHigh & gateLow) == 4'h0;
  endproperty
  a_gateExclusive: assert property (p_gateExclusive) else $error("gates overlap");
  property p_deadTime;
    ((gateHigh & $past(gateLow)) | (gateLow & $past(gateHigh))) == 4'h0;
  endproperty
  a_deadTime: assert property (p_deadTime) else $error("no dead cycle");
  // ==========================================
  // Enable and start-up
  property p_readyRise;
    $rose(chipEnable) |=> chipReady;
  endproperty
  a_readyRise: assert property (p_readyRise) else $error("ready late");
  property p_disable;
    !chipEnable |=> !chipReady && chanEnable == 4'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("not disabled");
  property p_startMask;
    $rose(chipReady) |-> ##[0:2] chanEnable == (nvmAlwaysOn | (nvmGpioCtl & gpioIn));
  endproperty
  a_startMask: assert property (p_startMask) else $error("start mask wrong");
  // ==========================================
  // Channel protection
  property p_ocpOff;
    chipReady && ocpTrip[0] |-> ##2 !chanEnable[0];
  endproperty
  a_ocpOff: assert property (p_ocpOff) else $error("overcurrent not shut");
  property p_ocpRestart;
    $fell(chanEnable[0]) && $past(ocpTrip[0]) |->
      (!chanEnable[0])[*8] ##[RS_LO:RS_HI] $rose(chanEnable[0]);
  endproperty
  a_ocpRestart: assert property (p_ocpRestart) else $error("restart timing");
  property p_ovpOff;
    chipReady && ovpTrip[1] |-> ##2 (!chanEnable[1])[*6];
  endproperty
  a_ovpOff: assert property (p_ovpOff) else $error("overvoltage not shut");
endmodule : pfs_top_sva
bind pfs_top pfs_top_sva #(.OCP_RESTART_CYCLES(OCP_RESTART_CYCLES)) pfs_top_sva_i (.mclk,
  .rst_n, .chipEnable, .nvmAlwaysOn, .nvmGpioCtl, .gpioIn, .ovpTrip, .ocpTrip, .chipReady,
  .chanEnable, .gateHigh, .gateLow);

/* File: pfs_top_bench.sv */
// Self-checking bench for the power rail fault supervisor
`timescale 1ns/1ns
`include "pfs_defs.svh"
module pfs_top_bench
  import pfs_pkg::*;
();
  localparam int OUTPUT_OVERCURRENT_PROTECT = 16;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic chipEnable = 1'b0;
  pfs_chan_t nvmAlwaysOn = 4'h1;
  pfs_chan_t nvmGpioCtl = 4'h6;
  pfs_chan_t gpioIn = 4'h2;
  pfs_chan_t ovpTrip = 4'h0;
  pfs_chan_t ocpTrip = 4'h0;
  pfs_chan_t pwmDrive = 4'h0;
  pfs_byte_t priAdc = 8'h78;
  pfs_byte_t secAdc = 8'h7a;
  logic [6:0] tempAdc = 7'h14;
  pfs_byte_t [3:0] voutAdc = {8'h66, 8'h64, 8'h32, 8'h13};
  logic scl, sdaWire, sdaOut, sdaOe, chipReady, uvWarnGpio;
  pfs_chan_t chanEnable, gateHigh, gateLow;
  pfs_byte_t [3:0] target;
  int miscompares = 0;
  int checks_done = 0;
  pfs_top #(.OCP_RESTART_CYCLES(OUTPUT_OVERCURRENT_PROTECT)) pfs_top_i (.mclk(mclk), .rst_n(rst_n),
    .chipEnable(chipEnable), .nvmAlwaysOn(nvmAlwaysOn), .nvmGpioCtl(nvmGpioCtl),
    .gpioIn(gpioIn), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .primaryInputAdc(priAdc), .secondaryInputAdc(secAdc), .junctionTempAdc(tempAdc),
    .outputVoltageAdc(voutAdc), .ovpTrip(ovpTrip), .ocpTrip(ocpTrip), .pwmDrive(pwmDrive),
    .chipReady(chipReady), .chanEnable(chanEnable), .gateHigh(gateHigh), .gateLow(gateLow),
    .outputVoltageTarget(target), .uvWarnGpio(uvWarnGpio));
  pfs_host_model pfs_host_model_i (.mclk(mclk), .sdaOe(sdaOe), .scl(scl), .sdaWire(sdaWire));
  // ==========================================
  // Clock and a free-running PWM pattern, each channel at its own rate
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) pwmDrive <= #2 pwmDrive + 4'h1;
  // ==========================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : step
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_op(input logic rd, input pfs_byte_t a, input pfs_byte_t v);
    pfs_byte_t q;
    logic ok;
    pfs_host_model_i.access(rd, `PFS_I2C_ADDR, a, v, q, ok);
    check("ack", ok, 1'b1);
    if (rd) check($sformatf("register %h", a), q, v);
  endtask : reg_op
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Scenarios
  task automatic test_start();
    pfs_byte_t q;
    logic ok;
    check("targets", target, {4{`PFS_RST_VOUT_TARGET}});
    pfs_host_model_i.access(1'b0, `PFS_I2C_ADDR, 8'h00, 8'h0f, q, ok);
    check("ack before ready", ok, 1'b0);
    chipEnable = 1'b1;
    step(4);
    check("ready", chipReady, 1'b1);
    check("start enables", chanEnable, 4'h3);
    pfs_host_model_i.access(1'b0, 7'h49, 8'h00, 8'h0f, q, ok);
    check("foreign ack", ok, 1'b0);
    reg_op(1'b1, `PFS_OFS_EN_CONFIG, 8'h61);
    reg_op(1'b1, `PFS_OFS_PRI_READBACK, priAdc);
    reg_op(1'b1, `PFS_OFS_SEC_READBACK, secAdc);
    reg_op(1'b1, `PFS_OFS_TEMP_READBACK, {1'b0, tempAdc});
    reg_op(1'b1, `PFS_OFS_THERM_SHDN, {1'b0, `PFS_RST_THERM_SHDN});
    reg_op(1'b0, `PFS_OFS_THERM_SHDN, 8'hff);
    reg_op(1'b1, `PFS_OFS_THERM_SHDN, 8'h7f);
    reg_op(1'b0, 8'h0f, 8'h5a);
    reg_op(1'b1, 8'h0f, 8'h00);
    $display("test start done");
  endtask : test_start
  task automatic test_targets();
    reg_op(1'b0, `PFS_OFS_CH_EN_CMD, 8'h0c);
    check("serial enables", chanEnable & 4'hc, 4'hc);
    for (int c = 0; c < 4; c++) begin
      reg_op(1'b0, pfs_byte_t'(8'h10 + c), voutAdc[c]);
      check("target", target[c], voutAdc[c]);
      reg_op(1'b1, pfs_byte_t'(8'h14 + c), voutAdc[c]);
    end
    $display("test targets done");
  endtask : test_targets
  task automatic test_trips();
    ovpTrip = 4'h2;
    step(3);
    ovpTrip = 4'h0;
    step(6);
    check("overvoltage latch", chanEnable[1], 1'b0);
    reg_op(1'b1, `PFS_OFS_CHAN_FLAGS, 8'h02);
    reg_op(1'b0, `PFS_OFS_CH_EN_CMD, 8'h0e);
    check("overvoltage cleared", chanEnable[1], 1'b1);
    ocpTrip = 4'h1;
    step(3);
    ocpTrip = 4'h0;
    check("overcurrent off", chanEnable[0], 1'b0);
    step(OUTPUT_OVERCURRENT_PROTECT - 6);
    check("overcurrent hold", chanEnable[0], 1'b0);
    step(12);
    check("overcurrent back", chanEnable[0], 1'b1);
    $display("test trips done");
  endtask : test_trips
  task automatic test_uv();
    // Warning at the exact level, fault at the exact level, recovery one step above
    reg_op(1'b0, `PFS_OFS_FAULT_CFG, 8'h0b);
    for (int s = 0; s < 2; s++) begin
      if (s == 0) priAdc = `PFS_RST_UV_WARN; else secAdc = `PFS_RST_UV_WARN;
      step(3);
      check("warn pin", uvWarnGpio, 1'b1);
      reg_op(1'b1, `PFS_OFS_PROT_FLAGS, pfs_byte_t'(8'h01 << s));
      if (s == 0) priAdc = `PFS_RST_UV_FAULT; else secAdc = `PFS_RST_UV_FAULT;
      step(3);
      check("uv shut", chanEnable, 4'h0);
      reg_op(1'b1, `PFS_OFS_PROT_FLAGS, pfs_byte_t'(8'h05 << s));
      if (s == 0) priAdc = 8'h47; else secAdc = 8'h47;
      step(3);
      check("warn pin off", uvWarnGpio, 1'b0);
      reg_op(1'b1, `PFS_OFS_PROT_FLAGS, 8'h00);
    end
    $display("test uv done");
  endtask : test_uv
  task automatic test_ot();
    reg_op(1'b0, `PFS_OFS_THERM_SHDN, 8'h2c);
    tempAdc = 7'h2a;
    reg_op(1'b1, `PFS_OFS_PROT_FLAGS, 8'h00);
    tempAdc = 7'h2b;
    reg_op(1'b1, `PFS_OFS_PROT_FLAGS, 8'h10);
    tempAdc = 7'h2a;
    reg_op(1'b0, `PFS_OFS_FAULT_CFG, 8'h07);
    reg_op(1'b1, `PFS_OFS_PROT_FLAGS, 8'h10);
    tempAdc = 7'h2c;
    step(3);
    check("ot shut", chanEnable, 4'h0);
    reg_op(1'b1, `PFS_OFS_PROT_FLAGS, 8'h30);
    reg_op(1'b0, `PFS_OFS_THERM_RESTART, 8'h28);
    tempAdc = 7'h27;
    step(3);
    reg_op(1'b1, `PFS_OFS_PROT_FLAGS, 8'h00);
    tempAdc = 7'h14;
    $display("test ot done");
  endtask : test_ot
  task automatic test_restart();
    pfs_byte_t q;
    logic ok;
    // The restart leaves the serial slave running, so its acknowledge completes; that ack is not judged
    pfs_host_model_i.access(1'b0, `PFS_I2C_ADDR, `PFS_OFS_CHIP_RESTART, 8'h01, q, ok);
    step(3);
    check("restart enables", chanEnable, 4'h3);
    reg_op(1'b1, `PFS_OFS_FAULT_CFG, `PFS_RST_FAULT_CFG);
    chipEnable = 1'b0;
    step(2);
    check("off ready", chipReady, 1'b0);
    check("off enables", chanEnable, 4'h0);
    chipEnable = 1'b1;
    step(3);
    check("on enables", chanEnable, 4'h3);
    $display("test restart done");
  endtask : test_restart
  // ==========================================
  // Main sequence and watchdog, about six times the expected run
  initial begin
    step(6);
    rst_n = 1'b1;
    step(2);
    test_start();
    test_targets();
    test_trips();
    test_uv();
    test_ot();
    test_restart();
    report_and_stop();
  end
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
endmodule : pfs_top_bench
